/* File: core/ufs_consts.vh */
// register offsets, bit positions and timing counts for the usart flag and status block
`ifndef UFS_CONSTS_VH
`define UFS_CONSTS_VH
`define UFS_OFF_CONTROL_A 6'h00
`define UFS_OFF_CONTROL_B 6'h04
`define UFS_OFF_IENCLR 6'h14
`define UFS_OFF_IENSET 6'h16
`define UFS_OFF_IFLAG 6'h18
`define UFS_OFF_STAT 6'h1A
`define UFS_OFF_SYNC 6'h1C
`define UFS_OFF_DATA 6'h28
`define UFS_B_DRE 0
`define UFS_B_TXC 1
`define UFS_B_RXC 2
`define UFS_B_RXS 3
`define UFS_B_HANDSHAKE_CHANGE_FLAG 4
`define UFS_B_RECEIVE_BREAK_FLAG 5
`define UFS_B_ERR 7
`define UFS_S_PARITY_ERROR_BIT 0
`define UFS_S_FRAMING_ERROR_BIT 1
`define UFS_S_OVF 2
`define UFS_S_CTS 3
`define UFS_S_ISF 4
`define UFS_S_COLLISION_BIT 5
`define UFS_S_TXE 6
`define UFS_A_SOFT_RESET 0
`define UFS_A_ENABLE 1
`define UFS_FRAME_FORMAT_LSB 24
`define UFS_TX_PAD_SELECT_LSB 16
`define UFS_B_RXEN 17
`define UFS_B_COLLISION_DETECT_ENABLE 8
`define UFS_B_START_OF_FRAME_DETECT_ENABLE 9
`define UFS_FRAME_FORMAT_PAR0 4'h1
`define UFS_FRAME_FORMAT_PAR1 4'h5
`define UFS_FRAME_FORMAT_ABD0 4'h4
`define UFS_FRAME_FORMAT_ABD1 4'h5
`define UFS_TX_PAD_SELECT_FLOW 2'h2
`define UFS_SYNC_CYC 3'h4
`define UFS_SYNC_PAT 8'h55
`define UFS_ZERO32 32'h0000_0000
`endif

/* File: core/ufs_usart_flags.v */
// interrupt flags, line status and sync-busy logic of a serial transceiver
`include "ufs_consts.vh"
module ufs_usart_flags #(
    parameter DW = 9
) (
    input wire MCLK,
    input wire RESETN,
    input wire [5:0] ADDR,
    input wire SEL,
    input wire WR,
    input wire [31:0] WDATA,
    output reg [31:0] RDATA,
    output reg PSLVERR,
    input wire CTS_PIN,
    input wire RX_START,
    input wire RX_DONE,
    input wire [DW-1:0] RX_CHAR,
    input wire RX_STOP1,
    input wire RX_PAR_BAD,
    input wire RX_BREAK,
    input wire RX_SYNC_DONE,
    input wire [7:0] RX_SYNC_VAL,
    input wire TX_COLLIDE,
    input wire TX_SHIFT_IDLE,
    input wire TX_TAKE,
    output reg TX_LOAD,
    output reg [DW-1:0] TX_CHAR,
    output reg IRQ
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers; every async input passes two flops
// the line engine runs on its own clock, so every strobe and handshake level it
// hands over is treated as asynchronous here; the character and frame data are not. An event is seen three
// edges after its pin rises: two edges to synchronise, one to find the edge.
// A strobe shorter than one bus clock can be missed. The line engine
// must stretch its strobes, which the partner model does.
reg [1:0] cts_s_r, st_s_r, dn_s_r, brk_s_r, syn_s_r, col_s_r, idl_s_r, tk_s_r;
reg cts_q_r;
always @(posedge MCLK) begin
    if (!RESETN) begin
        cts_s_r <= 2'b00; st_s_r <= 2'b00; dn_s_r <= 2'b00; brk_s_r <= 2'b00;
        syn_s_r <= 2'b00; col_s_r <= 2'b00; tk_s_r <= 2'b00;
        idl_s_r <= 2'b11; // shifter idles high; avoids a false edge after reset
        cts_q_r <= 1'b0;
    end else begin
        cts_s_r <= {cts_s_r[0], CTS_PIN};
        st_s_r <= {st_s_r[0], RX_START};
        dn_s_r <= {dn_s_r[0], RX_DONE};
        brk_s_r <= {brk_s_r[0], RX_BREAK};
        syn_s_r <= {syn_s_r[0], RX_SYNC_DONE};
        col_s_r <= {col_s_r[0], TX_COLLIDE};
        idl_s_r <= {idl_s_r[0], TX_SHIFT_IDLE};
        tk_s_r <= {tk_s_r[0], TX_TAKE};
        cts_q_r <= cts_s_r[1];
    end
end

// edge detectors look only at second stage, never the first
// the idle detector resets to the idle level of its pin, so a shifter that
// is idle out of reset does not look like a finished frame
reg st_q_r, dn_q_r, brk_q_r, syn_q_r, col_q_r, tk_q_r, idl_q_r;
always @(posedge MCLK) begin
    if (!RESETN) begin
        st_q_r <= 1'b0; dn_q_r <= 1'b0; brk_q_r <= 1'b0;
        syn_q_r <= 1'b0; col_q_r <= 1'b0; tk_q_r <= 1'b0;
        idl_q_r <= 1'b1;
    end else begin
        st_q_r <= st_s_r[1]; dn_q_r <= dn_s_r[1]; brk_q_r <= brk_s_r[1];
        syn_q_r <= syn_s_r[1]; col_q_r <= col_s_r[1]; tk_q_r <= tk_s_r[1];
        idl_q_r <= idl_s_r[1];
    end
end
// a rising idle level marks the end of a shifted frame
wire ev_idle = idl_s_r[1] & ~idl_q_r;
wire ev_start = st_s_r[1] & ~st_q_r;
wire ev_done = dn_s_r[1] & ~dn_q_r;
wire ev_brk = brk_s_r[1] & ~brk_q_r;
wire ev_sync = syn_s_r[1] & ~syn_q_r;
wire ev_col = col_s_r[1] & ~col_q_r;
wire ev_take = tk_s_r[1] & ~tk_q_r;
wire ev_cts = cts_s_r[1] ^ cts_q_r;

////////////////////////////////////////////////////////////////////////////////
// bus decode; character and frame data assumed stable before done strobe syncs
function hit;
    input [5:0] a;
    input [5:0] off;
    begin
        hit = (a[5:1] == off[5:1]);
    end
endfunction
wire wr_acc = SEL & WR;
wire rd_acc = SEL & ~WR;
wire w_control_a = wr_acc & hit(ADDR, `UFS_OFF_CONTROL_A);
wire w_control_b = wr_acc & hit(ADDR, `UFS_OFF_CONTROL_B);
wire w_iclr = wr_acc & hit(ADDR, `UFS_OFF_IENCLR);
wire w_iset = wr_acc & hit(ADDR, `UFS_OFF_IENSET);
wire w_flag = wr_acc & hit(ADDR, `UFS_OFF_IFLAG);
wire w_stat = wr_acc & hit(ADDR, `UFS_OFF_STAT);
wire w_data = wr_acc & hit(ADDR, `UFS_OFF_DATA);
wire r_data = rd_acc & hit(ADDR, `UFS_OFF_DATA);

////////////////////////////////////////////////////////////////////////////////
// control registers and sync-busy counters
// the crossing delay is a fixed count rather than a real handshake: the
// core clock domain is not modelled here, and the count stands in for it.
// a second control_b write while busy is dropped and flagged, never queued
reg [31:0] control_a_r;
reg [31:0] control_b_r;
reg [2:0] sync_pending_r;
reg [2:0] cnt_rst_r, cnt_en_r, cnt_b_r;
wire b_busy_err = w_control_b & sync_pending_r[2];
wire enabled = control_a_r[`UFS_A_ENABLE];
wire [3:0] frame_format = control_a_r[`UFS_FRAME_FORMAT_LSB+3:`UFS_FRAME_FORMAT_LSB];
wire [1:0] tx_pad_select = control_a_r[`UFS_TX_PAD_SELECT_LSB+1:`UFS_TX_PAD_SELECT_LSB];
wire rx_en = control_b_r[`UFS_B_RXEN];
wire collision_detect_enable = control_b_r[`UFS_B_COLLISION_DETECT_ENABLE];
wire start_of_frame_detect_enable = control_b_r[`UFS_B_START_OF_FRAME_DETECT_ENABLE];
wire autobaud = (frame_format == `UFS_FRAME_FORMAT_ABD0) | (frame_format == `UFS_FRAME_FORMAT_ABD1);
wire parity_on = (frame_format == `UFS_FRAME_FORMAT_PAR0) | (frame_format == `UFS_FRAME_FORMAT_PAR1);
wire rx_off = w_control_b & enabled & ~b_busy_err & ~WDATA[`UFS_B_RXEN];
always @(posedge MCLK) begin
    if (!RESETN) begin
        control_a_r <= `UFS_ZERO32;
        control_b_r <= `UFS_ZERO32;
        sync_pending_r <= 3'b000;
        cnt_rst_r <= 3'b000; cnt_en_r <= 3'b000; cnt_b_r <= 3'b000;
    end else begin
        // soft reset clears controls once its sync window expires
        if (sync_pending_r[`UFS_A_SOFT_RESET] && cnt_rst_r == 3'b001) begin
            control_a_r <= `UFS_ZERO32;
            control_b_r <= `UFS_ZERO32;
        end else begin
            if (w_control_a)
                control_a_r <= WDATA;
            if (w_control_b && !b_busy_err)
                control_b_r <= WDATA;
        end
        // each busy bit counts down a fixed crossing delay
        if (w_control_a && WDATA[`UFS_A_SOFT_RESET]) begin
            sync_pending_r[0] <= 1'b1; cnt_rst_r <= `UFS_SYNC_CYC;
        end else if (cnt_rst_r != 3'b000) begin
            cnt_rst_r <= cnt_rst_r - 3'b001;
            sync_pending_r[0] <= (cnt_rst_r != 3'b001);
        end
        if (w_control_a && (WDATA[`UFS_A_ENABLE] != enabled || WDATA[`UFS_A_ENABLE])) begin
            sync_pending_r[1] <= 1'b1; cnt_en_r <= `UFS_SYNC_CYC;
        end else if (cnt_en_r != 3'b000) begin
            cnt_en_r <= cnt_en_r - 3'b001;
            sync_pending_r[1] <= (cnt_en_r != 3'b001);
        end
        if (w_control_b && enabled && !b_busy_err) begin
            sync_pending_r[2] <= 1'b1; cnt_b_r <= `UFS_SYNC_CYC;
        end else if (cnt_b_r != 3'b000) begin
            cnt_b_r <= cnt_b_r - 3'b001;
            sync_pending_r[2] <= (cnt_b_r != 3'b001);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// two-level receive buffer with per-character error bits
// the receive-complete flag is derived from the fill count, so it can never
// disagree with the buffer; a receiver disable empties it in one cycle
reg [DW+1:0] rxb_r [0:1]; // {parity_error_bit, framing_error_bit, data}
reg [1:0] rx_cnt_r;
reg rx_shift_full_r;
reg ovf_pend_r;
wire rx_pop = r_data & (rx_cnt_r != 2'b00);
wire [DW+1:0] rx_new = {RX_PAR_BAD & parity_on, ~RX_STOP1, RX_CHAR};
always @(posedge MCLK) begin
    if (!RESETN || rx_off) begin
        rx_cnt_r <= 2'b00; rx_shift_full_r <= 1'b0; ovf_pend_r <= 1'b0;
        rxb_r[0] <= {(DW+2){1'b0}}; rxb_r[1] <= {(DW+2){1'b0}};
    end else begin
        // overflow tagged onto the character next read
        if (ev_start && rx_cnt_r == 2'b10 && rx_shift_full_r)
            ovf_pend_r <= 1'b1;
        else if (rx_pop)
            ovf_pend_r <= 1'b0;
        if (rx_pop)
            rxb_r[0] <= rxb_r[1];
        if (ev_done && enabled && rx_en) begin
            if (rx_cnt_r == 2'b10 && !rx_pop)
                rx_shift_full_r <= 1'b1; // character parked in shifter
            else if (rx_cnt_r == 2'b00 || (rx_cnt_r == 2'b01 && rx_pop))
                rxb_r[0] <= rx_new;
            else
                rxb_r[1] <= rx_new;
        end else if (rx_pop && rx_shift_full_r) begin
            rx_shift_full_r <= 1'b0;
        end
        if (ev_done && enabled && rx_en && !(rx_cnt_r == 2'b10 && !rx_pop))
            rx_cnt_r <= rx_pop ? rx_cnt_r : rx_cnt_r + 2'b01;
        else if (rx_pop)
            rx_cnt_r <= rx_cnt_r - 2'b01;
    end
end
// the error bits are loaded only when a new character becomes the head of
// the buffer; loading them every cycle would undo a software clear at once
wire head_new = ev_done & enabled & rx_en & ((rx_cnt_r == 2'b00) | ((rx_cnt_r == 2'b01) & rx_pop));
wire head_shift = rx_pop & (rx_cnt_r == 2'b10);
wire set_f = head_new ? ~RX_STOP1 : (head_shift & rxb_r[1][DW]);
wire set_p = head_new ? (RX_PAR_BAD & parity_on) : (head_shift & rxb_r[1][DW+1]);
// limitation: a character parked in the shifter during overflow is not kept;
// only the overflow bit records that it was there

////////////////////////////////////////////////////////////////////////////////
// transmit holding register
reg tx_full_r;
always @(posedge MCLK) begin
    if (!RESETN) begin
        tx_full_r <= 1'b0; TX_LOAD <= 1'b0; TX_CHAR <= {DW{1'b0}};
    end else begin
        if (w_data) begin
            TX_CHAR <= WDATA[DW-1:0];
            tx_full_r <= 1'b1;
        end else if (ev_take) begin
            tx_full_r <= 1'b0;
        end
        TX_LOAD <= w_data ? 1'b1 : (ev_take ? 1'b0 : TX_LOAD);
    end
end

////////////////////////////////////////////////////////////////////////////////
// sticky flags: hardware set wins over software clear
reg [7:0] interrupt_enable_r;
reg err_flag_r, brk_flag_r, handshake_change_flag_flag_r, rxs_flag_r, txc_flag_r;
reg collision_bit_r, isf_r, ovf_r, framing_error_bit_r, parity_error_bit_r;
wire e_collision_bit = ev_col & collision_detect_enable;
wire e_isf = ev_sync & autobaud & (RX_SYNC_VAL != `UFS_SYNC_PAT);
wire e_ovf = ev_start & (rx_cnt_r == 2'b10) & rx_shift_full_r;
wire e_any = e_collision_bit | e_isf | e_ovf | (ev_done & (~RX_STOP1 | (RX_PAR_BAD & parity_on)));
wire [7:0] fw = WDATA[7:0];
wire [7:0] sw = WDATA[7:0];
always @(posedge MCLK) begin
    if (!RESETN) begin
        interrupt_enable_r <= 8'h00;
        err_flag_r <= 1'b0; brk_flag_r <= 1'b0; handshake_change_flag_flag_r <= 1'b0;
        rxs_flag_r <= 1'b0; txc_flag_r <= 1'b0;
        collision_bit_r <= 1'b0; isf_r <= 1'b0; ovf_r <= 1'b0; framing_error_bit_r <= 1'b0; parity_error_bit_r <= 1'b0;
    end else begin
        if (w_iset)
            interrupt_enable_r <= interrupt_enable_r | fw;
        else if (w_iclr)
            interrupt_enable_r <= interrupt_enable_r & ~fw;
        err_flag_r <= e_any | (err_flag_r & ~(w_flag & fw[`UFS_B_ERR]));
        brk_flag_r <= (ev_brk & autobaud) | (brk_flag_r & ~(w_flag & fw[`UFS_B_RECEIVE_BREAK_FLAG]));
        handshake_change_flag_flag_r <= ev_cts | (handshake_change_flag_flag_r & ~(w_flag & fw[`UFS_B_HANDSHAKE_CHANGE_FLAG]));
        rxs_flag_r <= (ev_start & start_of_frame_detect_enable)
                      | (rxs_flag_r & ~(w_flag & fw[`UFS_B_RXS]));
        // set only on the end of a frame with nothing pending; a level set
        // would make the software clear useless while the line stays idle
        txc_flag_r <= (ev_idle & ~tx_full_r)
                      | (txc_flag_r & ~w_data & ~(w_flag & fw[`UFS_B_TXC]));
        // clear by one or by receiver disable, event still wins
        collision_bit_r <= e_collision_bit | (collision_bit_r & ~(w_stat & sw[`UFS_S_COLLISION_BIT]) & ~rx_off);
        isf_r <= e_isf | (isf_r & ~(w_stat & sw[`UFS_S_ISF]) & ~rx_off);
        ovf_r <= e_ovf | (ovf_r & ~(w_stat & sw[`UFS_S_OVF]) & ~rx_off & ~(rx_pop & ~ovf_pend_r));
        // a pop hands over to the next character, whose own bits load at once
        framing_error_bit_r <= set_f | (framing_error_bit_r & ~(w_stat & sw[`UFS_S_FRAMING_ERROR_BIT]) & ~rx_off & ~rx_pop);
        parity_error_bit_r <= set_p | (parity_error_bit_r & ~(w_stat & sw[`UFS_S_PARITY_ERROR_BIT]) & ~rx_off & ~rx_pop);
    end
end
wire rxc_flag = (rx_cnt_r != 2'b00);
wire dre_flag = ~tx_full_r;
wire [7:0] interrupt_flags = {err_flag_r, 1'b0, brk_flag_r, handshake_change_flag_flag_r, rxs_flag_r,
                              rxc_flag, txc_flag_r, dre_flag};
wire cts_bit = (tx_pad_select == `UFS_TX_PAD_SELECT_FLOW) & cts_s_r[1];
wire [15:0] line_status = {9'h000, 1'b0, collision_bit_r, isf_r, cts_bit, ovf_r, framing_error_bit_r, parity_error_bit_r};

////////////////////////////////////////////////////////////////////////////////
// read mux, bus error and interrupt; all outputs registered
// read data is valid for one cycle after the strobe and zero otherwise, so
// a bus master that samples late sees zero rather than stale data.
// the interrupt is one cycle behind the flags, the price of a registered output.
// a refused control_b write raises the bus error for one cycle only
always @(posedge MCLK) begin
    if (!RESETN) begin
        RDATA <= `UFS_ZERO32; PSLVERR <= 1'b0; IRQ <= 1'b0;
    end else begin
        PSLVERR <= b_busy_err;
        IRQ <= |(interrupt_flags & interrupt_enable_r);
        if (!rd_acc)
            RDATA <= `UFS_ZERO32;
        else if (hit(ADDR, `UFS_OFF_IFLAG))
            RDATA <= {24'h00_0000, interrupt_flags};
        else if (hit(ADDR, `UFS_OFF_STAT))
            RDATA <= {16'h0000, line_status};
        else if (hit(ADDR, `UFS_OFF_SYNC))
            RDATA <= {29'h0000_0000, sync_pending_r};
        else if (hit(ADDR, `UFS_OFF_IENSET) || hit(ADDR, `UFS_OFF_IENCLR))
            RDATA <= {24'h00_0000, interrupt_enable_r};
        else if (hit(ADDR, `UFS_OFF_CONTROL_A))
            RDATA <= control_a_r;
        else if (hit(ADDR, `UFS_OFF_CONTROL_B))
            RDATA <= control_b_r;
        else if (r_data)
            RDATA <= {{(32-DW){1'b0}}, rxb_r[0][DW-1:0]};
        else
            RDATA <= `UFS_ZERO32;
    end
end

endmodule

/* File: verif/ufs_peer.sv */
// behavioural model of the remote transceiver and its line events
module ufs_peer (
    input wire logic mclk,
    input wire logic tx_load,
    input wire logic [8:0] tx_char,
    output logic cts, rx_start, rx_done, rx_stop1, rx_par_bad, rx_break, rx_sync_done,
    output logic [8:0] rx_char,
    output logic [7:0] rx_sync_val,
    output logic tx_collide, tx_idle, tx_take,
    output logic [8:0] last_tx
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cts, rx_start, rx_done, rx_stop1, rx_par_bad, rx_break, rx_sync_done} = 7'h00;
        {tx_collide, tx_take, rx_char, rx_sync_val, last_tx} = 29'h0000_0000;
        tx_idle = 1'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    // character fields held round the done edge, then scrambled so stale data shows
    task automatic send_char(input logic [8:0] ch, input logic stop);
        @(negedge mclk);
        rx_char = ch;
        rx_stop1 = stop;
        @(negedge mclk);
        rx_done = 1'h1;
        repeat (5) @(negedge mclk);
        rx_done = 1'h0;
        rx_char = ~ch;
        rx_stop1 = ~stop;
    endtask
    // a handshake level change together with a start condition
    task automatic line_events;
        @(negedge mclk);
        cts = ~cts;
        rx_start = 1'h1;
        repeat (4) @(negedge mclk);
        rx_start = 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // take a pending character after a delay, shift it, then report idle
    always begin
        @(negedge mclk);
        if (tx_load && !tx_take) begin
            repeat (3) @(negedge mclk);
            last_tx = tx_char;
            tx_take = 1'h1;
            tx_idle = 1'h0;
            for (int n = 0; n < 20 && tx_load; n++) @(negedge mclk);
            tx_take = 1'h0;
            repeat (6) @(negedge mclk);
            tx_idle = 1'h1;
        end
    end
endmodule

/* File: verif/ufs_usart_flags_sva.sv */
// port-level assertion checker for the flag, status and sync-busy block
module ufs_usart_flags_sva (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [5:0] ADDR,
    input wire logic SEL,
    input wire logic WR,
    input wire logic [31:0] WDATA,
    input wire logic [31:0] RDATA,
    input wire logic PSLVERR,
    input wire logic TX_TAKE,
    input wire logic TX_LOAD,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    logic en_r;
    logic [7:0] ien_r;
    wire cb_wr = SEL && WR && ADDR[5:1] == 5'h02;
    ////////////////////////////////////////////////////////////////////////
    // shadow of enable and interrupt enables; a soft reset write reads as disabled at once
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            en_r <= 1'h0;
            ien_r <= 8'h00;
        end else if (SEL && WR) begin
            if (ADDR[5:1] == 5'h00) en_r <= WDATA[1] && !WDATA[0];
            if (ADDR[5:1] == 5'h0B) ien_r <= ien_r | WDATA[7:0];
            if (ADDR[5:1] == 5'h0A) ien_r <= ien_r & ~WDATA[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // a read of one halfword slot, and two accepted-then-busy control_b writes
    sequence s_read(a);
        SEL && !WR && ADDR[5:1] == a;
    endsequence
    sequence s_cb_pair;
        en_r && cb_wr ##1 !PSLVERR ##1 cb_wr;
    endsequence
    a_rdata_idle_zero: assert property (!$past(SEL) |-> RDATA == 32'h0000_0000)
        else $error("read data not zero outside a read");
    a_flag_shape: assert property (s_read(5'h0C) |=> RDATA[31:8] == 24'h00_0000 && !RDATA[6])
        else $error("flag read shows reserved bits");
    a_txe_reads_zero: assert property (s_read(5'h0D) |=> RDATA[31:6] == 26'h000_0000)
        else $error("status read shows transmitter empty or reserved bits");
    a_sync_width: assert property (s_read(5'h0E) |=> RDATA[31:3] == 29'h0000_0000)
        else $error("sync read shows reserved bits");
    a_slverr_cause: assert property (PSLVERR |-> $past(cb_wr))
        else $error("bus error without a control_b write");
    a_slverr_busy: assert property (s_cb_pair |=> PSLVERR)
        else $error("control_b write while busy not refused");
    a_txload_set: assert property (SEL && WR && ADDR[5:1] == 5'h14 && !TX_LOAD |-> ##[1:2] TX_LOAD)
        else $error("data write did not load transmitter");
    a_txload_hold: assert property ($fell(TX_LOAD) |-> $past(TX_TAKE))
        else $error("pending data dropped before take");
    a_irq_masked: assert property (ien_r == 8'h00 && $past(ien_r) == 8'h00 |-> !IRQ)
        else $error("interrupt with all enables clear");
endmodule
bind ufs_usart_flags ufs_usart_flags_sva ufs_usart_flags_sva_inst (
    .MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR), .SEL(SEL), .WR(WR), .WDATA(WDATA),
    .RDATA(RDATA), .PSLVERR(PSLVERR), .TX_TAKE(TX_TAKE), .TX_LOAD(TX_LOAD), .IRQ(IRQ)
);

/* File: verif/usart_flag_status_sync_test.sv */
// self-checking testbench of the flag, status and sync-busy block
module usart_flag_status_sync_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'h0, RESETN = 1'h0, SEL = 1'h0, WR = 1'h0, PSLVERR, TX_LOAD, IRQ, err;
    logic [5:0] ADDR = 6'h00;
    logic [31:0] WDATA = 32'h0000_0000, RDATA, rd;
    logic [8:0] TX_CHAR, RX_CHAR, last_tx;
    logic [7:0] sync_val;
    logic cts, rs, rdn, st1, pb, brk, sd, col, idle, take;
    int n_fail = 0, tests_run = 0;
    ufs_usart_flags #(.DW(9)) ufs_usart_flags_inst (.MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR),
        .SEL(SEL), .WR(WR), .WDATA(WDATA), .RDATA(RDATA), .PSLVERR(PSLVERR), .CTS_PIN(cts),
        .RX_START(rs), .RX_DONE(rdn), .RX_CHAR(RX_CHAR), .RX_STOP1(st1), .RX_PAR_BAD(pb),
        .RX_BREAK(brk), .RX_SYNC_DONE(sd), .RX_SYNC_VAL(sync_val), .TX_COLLIDE(col),
        .TX_SHIFT_IDLE(idle), .TX_TAKE(take), .TX_LOAD(TX_LOAD), .TX_CHAR(TX_CHAR), .IRQ(IRQ));
    ufs_peer ufs_peer_inst (.mclk(MCLK), .tx_load(TX_LOAD), .tx_char(TX_CHAR), .cts(cts),
        .rx_start(rs), .rx_done(rdn), .rx_stop1(st1), .rx_par_bad(pb), .rx_break(brk),
        .rx_sync_done(sd), .rx_char(RX_CHAR), .rx_sync_val(sync_val), .tx_collide(col),
        .tx_idle(idle), .tx_take(take), .last_tx(last_tx));
    initial forever #12.5 MCLK = ~MCLK;
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one access: request held over one sampling edge, answer taken a cycle later
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(negedge MCLK);
        {SEL, WR, ADDR, WDATA} = {1'h1, w, a, d};
        @(negedge MCLK);
        SEL = 1'h0;
        rd = RDATA;
        err = PSLVERR;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    task automatic wait_irq(input logic e);
        for (int n = 0; n < 60 && IRQ !== e; n++) @(negedge MCLK);
        chk({31'h0, IRQ}, {31'h0, e});
        if (IRQ !== e) end_sim();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_sync;
        bus(1'h1, 6'h00, 32'h0000_0001);
        rdchk(6'h1C, 32'h0000_0001);
        cyc(8);
        bus(1'h1, 6'h00, 32'h0000_0002);
        rdchk(6'h1C, 32'h0000_0002);
        cyc(8);
        rdchk(6'h1C, 32'h0000_0000);
        bus(1'h1, 6'h04, 32'h0002_0300);
        bus(1'h1, 6'h04, 32'h0002_0300);
        chk({31'h0, err}, 32'h0000_0001);
        rdchk(6'h1C, 32'h0000_0004);
        cyc(8);
        rdchk(6'h1C, 32'h0000_0000);
    endtask
    task automatic t_tx;
        bus(1'h1, 6'h16, 32'h0000_0002);
        bus(1'h1, 6'h16, 32'h0000_0000);
        rdchk(6'h16, 32'h0000_0002);
        bus(1'h1, 6'h28, 32'h0000_01A5);
        rdchk(6'h18, 32'h0000_0000);
        wait_irq(1'h1);
        chk({23'h0, last_tx}, 32'h0000_01A5);
        bus(1'h1, 6'h18, 32'h0000_0001);
        rdchk(6'h18, 32'h0000_0003);
        bus(1'h1, 6'h18, 32'h0000_0002);
        rdchk(6'h18, 32'h0000_0001);
        wait_irq(1'h0);
    endtask
    task automatic t_rx;
        ufs_peer_inst.send_char(9'h0C3, 1'h0);
        cyc(4);
        rdchk(6'h18, 32'h0000_0085);
        rdchk(6'h1A, 32'h0000_0002);
        bus(1'h1, 6'h18, 32'h0000_0004);
        bus(1'h1, 6'h1A, 32'h0000_0040);
        rdchk(6'h18, 32'h0000_0085);
        rdchk(6'h1A, 32'h0000_0002);
        bus(1'h1, 6'h1A, 32'h0000_0002);
        rdchk(6'h1A, 32'h0000_0000);
        bus(1'h1, 6'h18, 32'h0000_0080);
        rdchk(6'h18, 32'h0000_0005);
        rdchk(6'h28, 32'h0000_00C3);
        rdchk(6'h18, 32'h0000_0001);
    endtask
    task automatic t_events;
        ufs_peer_inst.line_events();
        cyc(4);
        bus(1'h1, 6'h18, 32'h0000_0000);
        rdchk(6'h18, 32'h0000_0019);
        bus(1'h1, 6'h18, 32'h0000_0018);
        rdchk(6'h18, 32'h0000_0001);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(5);
        RESETN = 1'h1;
        rdchk(6'h1A, 32'h0000_0000);
        t_sync();
        t_tx();
        t_rx();
        t_events();
        end_sim();
    end
endmodule
